// ==== logic/cagen_top.sv ====
// Program counter and operand address generation
`timescale 1ns/1ps
module cagen_top (
    input  wire logic                   clk_sys,
    input  wire logic                   srst,
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire cagen_pkg::cagen_req_s  req,
    input  wire logic [15:0]            accumulator_pair,
    output logic                        mem_rd,
    output logic [15:0]                 mem_addr,
    input  wire logic                   mem_ack,
    input  wire logic [7:0]             mem_rdata,
    output logic [15:0]                 pc,
    output logic                        pc_load,
    output cagen_pkg::cagen_opnd_s      opnd,
    output logic                        opnd_valid
);
    cagen_pkg::cagen_st_e     st_ff;      // Sequencer state
    logic [15:0]              pc_ff;      // Program counter
    logic [15:0]              tbl_ff;     // Table entry address
    logic [7:0]               lo_ff;      // Table low byte
    logic                     ld_ff;      // Load pulse
    logic                     ov_ff;      // Operand valid
    cagen_pkg::cagen_opnd_s   opnd_ff;    // Registered operand
    cagen_pkg::cagen_opnd_s   opnd_c;     // Combinational operand
    logic [15:0]              nxt_seq;    // Following instruction
    logic                     take;       // Request accepted

    // Sign-extend and add with wrap
    function automatic logic [15:0] rel_tgt(input logic [15:0] base,
                                            input logic [7:0]  d);
        logic [16:0] s;
        s = {1'b0, base} + {1'b0, {8{d[7]}}, d};
        return s[15:0];
    endfunction

    // Table entry address from opcode
    function automatic logic [15:0] tbl_addr(input logic [7:0] op);
        // entry is base plus twice index
        return cagen_pkg::TABLE_BASE |
            {10'h000, op[cagen_pkg::TIDX_LSB +: cagen_pkg::TIDX_W], 1'b0};
    endfunction

    cagen_opnd u_opnd (
        .req  (req),
        .opnd (opnd_c)
    );

    assign take      = req_valid && req_ready;
    assign req_ready = (st_ff == cagen_pkg::CAGEN_ST_IDLE);
    assign nxt_seq   = pc_ff + {13'h0000, req.insn_len};
    assign pc        = pc_ff;
    assign pc_load   = ld_ff;
    assign opnd      = opnd_ff;
    assign opnd_valid = ov_ff;
    assign mem_rd    = (st_ff == cagen_pkg::CAGEN_ST_RDLO)
                    || (st_ff == cagen_pkg::CAGEN_ST_RDHI);
    assign mem_addr  = (st_ff == cagen_pkg::CAGEN_ST_RDHI)
                    ? tbl_ff + 16'h0001 : tbl_ff;

    // Sequencer state
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff <= cagen_pkg::CAGEN_ST_IDLE;
        end else begin
            case (st_ff)
                cagen_pkg::CAGEN_ST_IDLE: begin
                    if (take && req.br_kind == cagen_pkg::CAGEN_BR_TABLE) begin
                        st_ff <= cagen_pkg::CAGEN_ST_RDLO;
                    end
                end
                cagen_pkg::CAGEN_ST_RDLO: begin
                    if (mem_ack) begin
                        st_ff <= cagen_pkg::CAGEN_ST_RDHI;
                    end
                end
                cagen_pkg::CAGEN_ST_RDHI: begin
                    if (mem_ack) begin
                        st_ff <= cagen_pkg::CAGEN_ST_IDLE;
                    end
                end
                default: begin
                    st_ff <= cagen_pkg::CAGEN_ST_IDLE;
                end
            endcase
        end
    end

    // Table entry address and low byte
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tbl_ff <= 16'h0000;
            lo_ff  <= 8'h00;
        end else begin
            if (take && req.br_kind == cagen_pkg::CAGEN_BR_TABLE) begin
                tbl_ff <= tbl_addr(req.opcode);
            end
            if (st_ff == cagen_pkg::CAGEN_ST_RDLO && mem_ack) begin
                lo_ff <= mem_rdata;
            end
        end
    end

    // Program counter update
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pc_ff <= cagen_pkg::RESET_PC;
            ld_ff <= 1'b0;
        end else begin
            ld_ff <= 1'b0;
            if (take) begin
                case (req.br_kind)
                    cagen_pkg::CAGEN_BR_NONE:  pc_ff <= nxt_seq;
                    cagen_pkg::CAGEN_BR_REL: begin
                        pc_ff <= rel_tgt(nxt_seq, req.relative_displacement);
                        ld_ff <= 1'b1;
                    end
                    cagen_pkg::CAGEN_BR_ABS: begin
                        pc_ff <= req.absolute_address_operand;
                        ld_ff <= 1'b1;
                    end
                    cagen_pkg::CAGEN_BR_REG: begin
                        pc_ff <= accumulator_pair;
                        ld_ff <= 1'b1;
                    end
                    default: pc_ff <= pc_ff;
                endcase
            end else if (st_ff == cagen_pkg::CAGEN_ST_RDHI && mem_ack) begin
                pc_ff <= {mem_rdata, lo_ff};
                ld_ff <= 1'b1;
            end
        end
    end

    // Operand address register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            opnd_ff <= '0;
            ov_ff   <= 1'b0;
        end else begin
            ov_ff <= take && (req.op_kind != cagen_pkg::CAGEN_OP_NONE);
            if (take) begin
                opnd_ff <= opnd_c;
            end
        end
    end

    // Checks
    // relative target
    AST_REL: assert property (@(posedge clk_sys) disable iff (srst)
        take && req.br_kind == cagen_pkg::CAGEN_BR_REL |=>
        pc_load && pc == 16'($past(pc) + 16'($past(req.insn_len))
            + {{8{$past(req.relative_displacement[7])}},
               $past(req.relative_displacement)}))
        else $error("relative target wrong");
    AST_SEQ: assert property (@(posedge clk_sys) disable iff (srst)
        take && req.br_kind == cagen_pkg::CAGEN_BR_NONE |=>
        pc == $past(pc) + 16'($past(req.insn_len)) && !pc_load)
        else $error("sequential advance wrong");
    AST_ABS: assert property (@(posedge clk_sys) disable iff (srst)
        take && req.br_kind == cagen_pkg::CAGEN_BR_ABS |=>
        pc == $past(req.absolute_address_operand))
        else $error("absolute load wrong");
    AST_REG: assert property (@(posedge clk_sys) disable iff (srst)
        take && req.br_kind == cagen_pkg::CAGEN_BR_REG |=>
        pc == $past(accumulator_pair))
        else $error("register jump wrong");
    AST_TBL: assert property (@(posedge clk_sys) disable iff (srst)
        mem_rd |-> mem_addr >= 16'h0040 && mem_addr <= 16'h007F)
        else $error("table address out of range");
    AST_TBLSEQ: assert property (
        @(posedge clk_sys) disable iff (srst)
        st_ff == cagen_pkg::CAGEN_ST_RDHI && mem_ack |=>
        pc_load && pc[7:0] == $past(lo_ff))
        else $error("table load order wrong");
    AST_SHORT: assert property (@(posedge clk_sys) disable iff (srst)
        ov_ff && opnd.mem && !opnd.illegal && $past(req.op_kind)
        == cagen_pkg::CAGEN_OP_SHORT |->
        opnd.addr >= 16'hFE80 && opnd.addr <= 16'hFF1F)
        else $error("short address outside window");
    AST_SPEC: assert property (@(posedge clk_sys) disable iff (srst)
        take && req.op_kind == cagen_pkg::CAGEN_OP_SPEC |=>
        opnd.addr[15:8] == 8'hFF && opnd.addr[7:0] == $past(req.op_byte))
        else $error("special address wrong");
    AST_WORD: assert property (@(posedge clk_sys) disable iff (srst)
        take && req.op_kind == cagen_pkg::CAGEN_OP_SPEC
        && req.op_width == cagen_pkg::CAGEN_W_WORD |=> opnd.illegal)
        else $error("word special access allowed");

    COV_REL: cover property (@(posedge clk_sys)
        take && req.br_kind == cagen_pkg::CAGEN_BR_REL);
    COV_TBL: cover property (@(posedge clk_sys)
        st_ff == cagen_pkg::CAGEN_ST_RDHI && mem_ack);
    COV_SHORT: cover property (@(posedge clk_sys)
        take && req.op_kind == cagen_pkg::CAGEN_OP_SHORT);
endmodule

// ==== logic/cagen_pkg.sv ====
// Package of constants and carriers for the address generation block
// Notes on behaviour
// - No branch: counter advances by instruction length
// - Relative target: next address plus signed displacement
// - Relative form for short branch, conditionals
// - Absolute call/branch load sixteen-bit immediate
// - Table call index selects 40H-7FH entry
// - Register jump copies accumulator pair
// - Direct operand uses sixteen-bit immediate address
// - Short direct maps byte into FE80H-FF1FH
// - Short direct bit 8 from operand range
// - Word short direct operands sit at even addresses
// - Word register access only via short direct
// - Special register address is FFH plus byte
// - Three-bit code selects one of eight bytes
// - Two-bit code selects one of four pairs
// - Register access width per type, word even
package cagen_pkg;

    localparam int unsigned ADDR_W = 16;

    // Branch kinds from the decoder
    typedef enum logic [2:0] {
        CAGEN_BR_NONE  = 3'h0,
        CAGEN_BR_REL   = 3'h1,
        CAGEN_BR_ABS   = 3'h2,
        CAGEN_BR_TABLE = 3'h3,
        CAGEN_BR_REG   = 3'h4
    } cagen_br_e;

    // Operand addressing kinds
    typedef enum logic [2:0] {
        CAGEN_OP_NONE   = 3'h0,
        CAGEN_OP_DIRECT = 3'h1,
        CAGEN_OP_SHORT  = 3'h2,
        CAGEN_OP_SPEC   = 3'h3,
        CAGEN_OP_BREG   = 3'h4,
        CAGEN_OP_PREG   = 3'h5
    } cagen_op_e;

    // Access widths
    typedef enum logic [1:0] {
        CAGEN_W_BIT  = 2'h0,
        CAGEN_W_BYTE = 2'h1,
        CAGEN_W_WORD = 2'h2
    } cagen_w_e;

    // Branch sequencer states
    typedef enum logic [3:0] {
        CAGEN_ST_IDLE = 4'h1,
        CAGEN_ST_RDLO = 4'h2,
        CAGEN_ST_RDHI = 4'h4,
        CAGEN_ST_LOAD = 4'h8
    } cagen_st_e;

    // Address constants
    localparam logic [15:0] RESET_PC      = 16'h0000;
    localparam logic [15:0] TABLE_BASE    = 16'h0040;
    localparam logic [15:0] SHORT_BASE_HI = 16'hFE00;
    localparam logic [7:0]  SHORT_SFR_TOP = 8'h1F;
    localparam int unsigned SHORT_BIT8    = 8;
    localparam logic [7:0]  SPEC_HI       = 8'hFF;
    localparam logic [15:0] SPEC_SHORT_HI = 16'hFF1F;
    localparam logic [15:0] SFR_BASE      = 16'hFF00;
    localparam int unsigned TIDX_LSB      = 1;
    localparam int unsigned TIDX_W        = 5;
    localparam int unsigned INSN_LEN_W    = 3;

    // Request from the instruction decoder
    typedef struct packed {
        cagen_br_e             br_kind;
        logic [INSN_LEN_W-1:0] insn_len;
        logic [7:0]            relative_displacement;
        logic [15:0]           absolute_address_operand;
        logic [7:0]            opcode;
        cagen_op_e             op_kind;
        cagen_w_e              op_width;
        logic [7:0]            op_byte;
        logic [2:0]            byte_register_index;
        logic [1:0]            pair_register_index;
    } cagen_req_s;

    // Operand address result
    typedef struct packed {
        logic        mem;
        logic        reg8;
        logic        reg16;
        logic [15:0] addr;
        logic [2:0]  reg_idx;
        cagen_w_e    width;
        logic        illegal;
    } cagen_opnd_s;

endpackage

// ==== logic/cagen_opnd.sv ====
// Operand effective address former
`timescale 1ns/1ps
module cagen_opnd (
    input  wire cagen_pkg::cagen_req_s  req,
    output cagen_pkg::cagen_opnd_s      opnd
);
    // Combinational operand address decode
    always_comb begin
        opnd         = '0;
        opnd.width   = req.op_width;
        case (req.op_kind)
            cagen_pkg::CAGEN_OP_DIRECT: begin
                opnd.mem  = 1'b1;
                opnd.addr = req.absolute_address_operand;
                opnd.illegal = (req.op_width == cagen_pkg::CAGEN_W_WORD)
                    && (req.absolute_address_operand >= cagen_pkg::SFR_BASE);
            end
            cagen_pkg::CAGEN_OP_SHORT: begin
                opnd.mem  = 1'b1;
                opnd.addr = cagen_pkg::SHORT_BASE_HI | {8'h00, req.op_byte};
                opnd.addr[cagen_pkg::SHORT_BIT8] =
                    (req.op_byte <= cagen_pkg::SHORT_SFR_TOP);
                opnd.illegal = (req.op_width == cagen_pkg::CAGEN_W_WORD)
                    && req.op_byte[0];
                if ((req.op_byte > cagen_pkg::SHORT_SFR_TOP)
                    && !req.op_byte[7]) begin
                    opnd.illegal = 1'b1;
                end
            end
            cagen_pkg::CAGEN_OP_SPEC: begin
                opnd.mem  = 1'b1;
                opnd.addr = {cagen_pkg::SPEC_HI, req.op_byte};
                opnd.illegal = (req.op_width == cagen_pkg::CAGEN_W_WORD);
            end
            cagen_pkg::CAGEN_OP_BREG: begin
                opnd.reg8    = 1'b1;
                opnd.reg_idx = req.byte_register_index;
            end
            cagen_pkg::CAGEN_OP_PREG: begin
                opnd.reg16   = 1'b1;
                opnd.reg_idx = {1'b0, req.pair_register_index};
            end
            default: begin
                opnd.width = req.op_width;
            end
        endcase
    end
endmodule

// ==== test/cagen_mem_model.sv ====
// Memory model answering table reads of the address block
`timescale 1ns/1ps
module cagen_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        slow,
    input  wire logic        mem_rd,
    input  wire logic [15:0] mem_addr,
    output logic             mem_ack,
    output logic [7:0]       mem_rdata
);
    logic [1:0] wait_cnt;  // Cycles waited on this read

    // table bytes answered one per read
    always @(negedge clk_sys) begin
        mem_ack   <= 1'b0;
        // Data not held outside an answer
        mem_rdata <= ~mem_rdata;
        if (srst) begin
            wait_cnt <= 2'h0;
        end else if (mem_rd && !mem_ack) begin
            // Prompt answer, or three idle cycles when slow
            if (!slow || wait_cnt == 2'h3) begin
                mem_ack   <= 1'b1;
                mem_rdata <= mem_addr[7:0] ^ 8'hC3;
                wait_cnt  <= 2'h0;
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end

    // Known idle levels at time zero
    initial begin
        mem_ack   = 1'b0;
        mem_rdata = 8'hA5;
        wait_cnt  = 2'h0;
    end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the address generation block
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [15:0] pc;    // Counter expected with the operand
        logic [1:0]  kind;  // 0 memory, 1 byte reg, 2 pair reg
        logic [15:0] addr;  // Address, flagged byte index or pair index
        logic        ill;   // Illegal flag expected
        logic [1:0]  w;     // Access width expected
    } cagen_exp_s;
    logic                   clk_sys;
    logic                   srst;
    logic                   req_valid;
    logic                   req_ready;
    cagen_pkg::cagen_req_s  req;
    logic [15:0]            accumulator_pair;
    logic                   mem_rd;
    logic [15:0]            mem_addr;
    logic                   mem_ack;
    logic [7:0]             mem_rdata;
    logic [15:0]            pc;
    logic                   pc_load;
    cagen_pkg::cagen_opnd_s opnd;
    logic                   opnd_valid;
    logic                   slow;      // Partner answer speed
    logic [15:0]            mpc;       // Model program counter
    integer                 seed;
    int                     error_cnt;
    int                     samples_checked;
    logic [15:0]            q_pc[$];   // Expected branch targets
    cagen_exp_s             q_op[$];   // Expected operand results
    cagen_exp_s             e_cur;
    logic [7:0]             sv[6];

    cagen_top u_cagen_top (.clk_sys(clk_sys), .srst(srst),
        .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .accumulator_pair(accumulator_pair), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .pc(pc), .pc_load(pc_load), .opnd(opnd), .opnd_valid(opnd_valid));
    cagen_mem_model u_cagen_mem_model (.clk_sys(clk_sys), .srst(srst),
        .slow(slow), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // Free running core clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task print_verdict;
        $display("Errors %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One request: drive, wait for take, note expectations
    task automatic go(input cagen_pkg::cagen_br_e b,
                      input cagen_pkg::cagen_op_e o,
                      input cagen_pkg::cagen_w_e w, input logic [15:0] v);
        logic [31:0] r;
        logic [2:0]  len;
        logic [7:0]  ta;
        logic [15:0] nxt;
        cagen_exp_s  e;
        int          n;
        r = $random(seed);
        len = {1'b0, r[10:9]} + 3'h1;
        @(negedge clk_sys);
        req.br_kind = b;
        req.insn_len = len;
        req.relative_displacement = v[7:0];
        req.absolute_address_operand = v;
        req.opcode = {r[7:6], v[4:0], r[0]};
        req.op_kind = o;
        req.op_width = w;
        req.op_byte = v[7:0];
        req.byte_register_index = v[2:0];
        req.pair_register_index = v[1:0];
        accumulator_pair = r[31:16];
        slow = r[8];
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 50) check("ready wait", 16'h1, 16'h0);
        nxt = mpc + 16'(len);
        ta = 8'h40 + {2'h0, v[4:0], 1'b0};
        case (b)
            cagen_pkg::CAGEN_BR_REL: nxt = nxt + {{8{v[7]}}, v[7:0]};
            cagen_pkg::CAGEN_BR_ABS: nxt = v;
            cagen_pkg::CAGEN_BR_TABLE:
                nxt = {(ta + 8'h1) ^ 8'hC3, ta ^ 8'hC3};
            cagen_pkg::CAGEN_BR_REG: nxt = r[31:16];
            default: ;
        endcase
        e = '{pc: nxt, kind: 2'h0, addr: v, ill: 1'b0, w: w};
        case (o)
            cagen_pkg::CAGEN_OP_DIRECT:
                e.ill = (w == cagen_pkg::CAGEN_W_WORD) && (v >= 16'hFF00);
            cagen_pkg::CAGEN_OP_SHORT: begin
                e.addr = {7'h7F, (v[7:0] < 8'h20), v[7:0]};
                e.ill = ((v[7:0] >= 8'h20) && (v[7:0] <= 8'h7F))
                    || ((w == cagen_pkg::CAGEN_W_WORD) && v[0]);
            end
            cagen_pkg::CAGEN_OP_SPEC: begin
                e.addr = {8'hFF, v[7:0]};
                e.ill = (w == cagen_pkg::CAGEN_W_WORD);
            end
            cagen_pkg::CAGEN_OP_BREG: begin
                e.kind = 2'h1;
                e.addr = {12'h0, 1'b1, v[2:0]};
            end
            cagen_pkg::CAGEN_OP_PREG: begin
                e.kind = 2'h2;
                e.addr = {14'h0, v[1:0]};
            end
            default: ;
        endcase
        @(posedge clk_sys);
        mpc = nxt;
        if (b != cagen_pkg::CAGEN_BR_NONE) q_pc.push_back(nxt);
        if (o != cagen_pkg::CAGEN_OP_NONE) q_op.push_back(e);
    endtask

    // Result watcher takes the oldest note per result pulse
    always @(negedge clk_sys) begin
        if (srst === 1'b0 && pc_load === 1'b1) begin
            if (q_pc.size() == 0) check("spare pc_load", 16'h0, 16'h1);
            else check("branch pc", q_pc.pop_front(), pc);
        end
        if (srst === 1'b0 && opnd_valid === 1'b1) begin
            if (q_op.size() == 0) begin
                check("spare opnd_valid", 16'h0, 16'h1);
            end else begin
                e_cur = q_op.pop_front();
                check("sequential pc", e_cur.pc, pc);
                check("illegal", {15'h0, e_cur.ill},
                      {15'h0, opnd.illegal});
                check("width", {14'h0, e_cur.w},
                      {14'h0, opnd.width});
                if (e_cur.kind == 2'h0 && !e_cur.ill) begin
                    check("mem addr", e_cur.addr, opnd.addr);
                    check("mem flag", 16'h1, {15'h0, opnd.mem});
                end
                if (e_cur.kind == 2'h1)
                    check("byte reg", e_cur.addr,
                          {12'h0, opnd.reg8, opnd.reg_idx});
                if (e_cur.kind == 2'h2) begin
                    check("pair flag", 16'h1, {15'h0, opnd.reg16});
                    check("pair idx", e_cur.addr,
                          {13'h0, opnd.reg_idx});
                end
            end
        end
    end

    // Watchdog against a hang
    initial begin
        #20000;
        error_cnt++;
        print_verdict;
    end

    // Main sequence
    initial begin
        seed = 32'hA4DC1F4D;
        srst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        accumulator_pair = 16'h0000;
        slow = 1'b0;
        mpc = 16'h0000;
        error_cnt = 0;
        samples_checked = 0;
        sv = '{8'h80, 8'hFF, 8'h00, 8'h1F, 8'h50, 8'h20};
        repeat (10) @(negedge clk_sys);
        srst = 1'b0;
        check("reset pc", 16'h0000, pc);
        check("reset pc_load", 16'h0, {15'h0, pc_load});
        for (int i = 0; i < 6; i++)
            go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_SHORT,
               cagen_pkg::CAGEN_W_BYTE, {8'h0, sv[i]});
        go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_SHORT,
           cagen_pkg::CAGEN_W_WORD, 16'h0010);
        go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_SHORT,
           cagen_pkg::CAGEN_W_WORD, 16'h0011);
        go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_SHORT,
           cagen_pkg::CAGEN_W_WORD, 16'h0081);
        go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_DIRECT,
           cagen_pkg::CAGEN_W_WORD, 16'hFE80);
        go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_DIRECT,
           cagen_pkg::CAGEN_W_BYTE, 16'($random(seed)));
        go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_DIRECT,
           cagen_pkg::CAGEN_W_WORD, 16'hFF10);
        go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_SPEC,
           cagen_pkg::CAGEN_W_BIT, 16'h00A3);
        go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_SPEC,
           cagen_pkg::CAGEN_W_WORD, 16'h0012);
        for (int i = 0; i < 8; i++)
            go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_BREG,
               cagen_pkg::CAGEN_W_BYTE, 16'(i));
        for (int i = 0; i < 4; i++)
            go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_PREG,
               cagen_pkg::CAGEN_W_WORD, 16'(i));
        go(cagen_pkg::CAGEN_BR_ABS, cagen_pkg::CAGEN_OP_NONE,
           cagen_pkg::CAGEN_W_BYTE, 16'hFFF0);
        go(cagen_pkg::CAGEN_BR_REL, cagen_pkg::CAGEN_OP_NONE,
           cagen_pkg::CAGEN_W_BYTE, 16'h007F);
        go(cagen_pkg::CAGEN_BR_ABS, cagen_pkg::CAGEN_OP_NONE,
           cagen_pkg::CAGEN_W_BYTE, 16'h0005);
        go(cagen_pkg::CAGEN_BR_REL, cagen_pkg::CAGEN_OP_NONE,
           cagen_pkg::CAGEN_W_BYTE, 16'h0080);
        for (int i = 0; i < 8; i++)
            go(cagen_pkg::CAGEN_BR_REL, cagen_pkg::CAGEN_OP_NONE,
               cagen_pkg::CAGEN_W_BYTE, 16'($random(seed)));
        for (int i = 0; i < 6; i++)
            go(cagen_pkg::CAGEN_BR_TABLE, cagen_pkg::CAGEN_OP_NONE,
               cagen_pkg::CAGEN_W_BYTE, (i == 0) ? 16'h0000 : (i == 1)
               ? 16'h001F : 16'($random(seed)));
        go(cagen_pkg::CAGEN_BR_NONE, cagen_pkg::CAGEN_OP_BREG,
           cagen_pkg::CAGEN_W_BYTE, 16'h0002);
        go(cagen_pkg::CAGEN_BR_REG, cagen_pkg::CAGEN_OP_NONE,
           cagen_pkg::CAGEN_W_BYTE, 16'h0000);
        @(negedge clk_sys);
        req_valid = 1'b0;
        repeat (20) @(negedge clk_sys);
        check("pending notes", 16'h0, 16'(q_pc.size() + q_op.size()));
        print_verdict;
    end
endmodule
